// ---- rtl/frame_if.sv ----
`timescale 1ns/100ps
interface frame_if;
    logic done;
    logic [15:0] byte_cnt;
    logic crc_err;
    logic len_range;
    logic len_err;
    logic sym_err;
    logic too_long;
    modport check (output done, byte_cnt, crc_err, len_range, len_err, sym_err, too_long);
    modport gen (input done, byte_cnt, crc_err, len_range, len_err, sym_err, too_long);
endinterface

// ---- rtl/rsv_pkg.sv ----
package rsv_pkg;
    localparam int RSV_W = 24;
    localparam int BIT_OK = 23;
    localparam int BIT_RANGE = 22;
    localparam int BIT_LEN_ERR = 21;
    localparam int BIT_CRC_ERR = 20;
    localparam int BIT_CARRIER = 18;
    localparam int BIT_IGNORED = 16;
    localparam int CNT_W = 16;
    // 1500 bytes
    localparam logic [15:0] MAX_LEN_FIELD = 16'h05dc;
    localparam int LONG_BIT_TIMES = 50000;
    localparam logic [15:0] LONG_BYTES = 16'(LONG_BIT_TIMES / 8);
    localparam logic [15:0] HDR_BYTES = 16'h000e;
    localparam logic [15:0] FCS_BYTES = 16'h0004;
    localparam logic [15:0] MIN_DATA = 16'h002e;
    localparam logic [15:0] TL_HI_IDX = 16'h000c;
    localparam logic [15:0] TL_LO_IDX = 16'h000d;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [31:0] CRC_INIT = 32'hffffffff;
    localparam logic [31:0] CRC_POLY = 32'hedb88320;
    localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0c;
    localparam int IRQ_W = 4;
    localparam int IRQ_VEC = 0;
    localparam int IRQ_CRC = 1;
    localparam int IRQ_CARRIER = 2;
    localparam int IRQ_IGNORED = 3;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;
    typedef enum logic [3:0] {
        OUT_IDLE = 4'h1,
        OUT_B0 = 4'h2,
        OUT_B1 = 4'h4,
        OUT_B2 = 4'h8
    } out_state_type;
endpackage

// ---- rtl/rx_frame_checker.sv ----
`timescale 1ns/100ps
module rx_frame_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic rx_frame,
    input wire logic rx_byte_en,
    input wire logic [7:0] rx_data,
    input wire logic rx_sym_err,
    frame_if.check fr
);
    import rsv_pkg::*;

    typedef struct packed {
        logic in_frame;
        logic [15:0] cnt;
        logic [15:0] tl;
        logic [31:0] crc;
        logic sym;
        logic done;
        logic [15:0] r_cnt;
        logic r_crc;
        logic r_range;
        logic r_len;
        logic r_sym;
        logic r_long;
    } chk_state_type;

    chk_state_type s_ff, nxt_s;

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++)
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        return r;
    endfunction

    always_comb
    begin
        logic [15:0] data_len;
        logic [15:0] expect_len;
        data_len = '0;
        expect_len = '0;
        nxt_s = s_ff;
        nxt_s.done = 1'b0;
        if (rx_frame && rx_byte_en)
        begin
            nxt_s.in_frame = 1'b1;
            if (!s_ff.in_frame)
            begin
                nxt_s.cnt = 16'h0001;
                nxt_s.crc = crc_byte(CRC_INIT, rx_data);
                nxt_s.tl = '0;
                nxt_s.sym = rx_sym_err;
            end
            else
            begin
                if (s_ff.cnt != CNT_MAX)
                    nxt_s.cnt = s_ff.cnt + 16'h0001;
                nxt_s.crc = crc_byte(s_ff.crc, rx_data);
                if (s_ff.cnt == TL_HI_IDX || s_ff.cnt == TL_LO_IDX)
                    nxt_s.tl = {s_ff.tl[7:0], rx_data};
                nxt_s.sym = s_ff.sym | rx_sym_err;
            end
        end
        else if (s_ff.in_frame)
            nxt_s.sym = s_ff.sym | rx_sym_err;
        if (!rx_frame && s_ff.in_frame)
        begin
            if (s_ff.cnt > HDR_BYTES + FCS_BYTES)
                data_len = s_ff.cnt - HDR_BYTES - FCS_BYTES;
            expect_len = (s_ff.tl < MIN_DATA) ? MIN_DATA : s_ff.tl;
            nxt_s.in_frame = 1'b0;
            nxt_s.done = 1'b1;
            nxt_s.r_cnt = s_ff.cnt;
            nxt_s.r_crc = (s_ff.crc != CRC_RESIDUE);
            nxt_s.r_range = (s_ff.tl > MAX_LEN_FIELD);
            nxt_s.r_len = (s_ff.tl <= MAX_LEN_FIELD) && (data_len != expect_len);
            nxt_s.r_sym = s_ff.sym;
            nxt_s.r_long = (s_ff.cnt > LONG_BYTES);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s_ff <= '0;
        else
            s_ff <= nxt_s;
    end

    assign fr.done = s_ff.done;
    assign fr.byte_cnt = s_ff.r_cnt;
    assign fr.crc_err = s_ff.r_crc;
    assign fr.len_range = s_ff.r_range;
    assign fr.len_err = s_ff.r_len;
    assign fr.sym_err = s_ff.r_sym;
    assign fr.too_long = s_ff.r_long;

    a_type_range: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (!rx_frame && s_ff.in_frame) |=> fr.done && (fr.len_range == ($past(s_ff.tl) > MAX_LEN_FIELD)))
        else $error("type/length range flag wrong");

    a_length_excl: assert property (
        @(posedge hclk) disable iff (!hresetn)
        fr.done |-> !(fr.len_err && fr.len_range))
        else $error("length error raised on a type field");
endmodule

// ---- rtl/rx_status_vector_gen.sv ----
`timescale 1ns/100ps
module rx_status_vector_gen (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic rx_frame,
    input wire logic rx_byte_en,
    input wire logic [7:0] rx_data,
    input wire logic rx_sym_err,
    input wire logic carrier_event,
    input wire logic drop_event,
    output logic [rsv_pkg::RSV_W-1:0] status_vector,
    output logic status_valid,
    output logic [7:0] vec_byte,
    output logic vec_byte_valid,
    output logic irq
);
    import rsv_pkg::*;

    typedef struct packed {
        logic [RSV_W-1:0] rsv;
        logic rsv_valid;
        logic carrier_seen;
        logic ignored_seen;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic ctrl_en;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic ready;
        logic resp;
        logic irq;
        out_state_type ost;
        logic [7:0] ob;
        logic ob_valid;
    } gen_state_type;

    gen_state_type s_ff, nxt_s;
    frame_if fr_bus ();

    rx_frame_checker u_chk (
        .hclk(hclk),
        .hresetn(hresetn),
        .rx_frame(rx_frame),
        .rx_byte_en(rx_byte_en),
        .rx_data(rx_data),
        .rx_sym_err(rx_sym_err),
        .fr(fr_bus)
    );

    function automatic logic [31:0] read_reg(input gen_state_type st, input logic [7:0] a);
        logic [31:0] d;
        d = '0;
        case (a)
            ADDR_STATUS: d = {8'h00, st.rsv};
            ADDR_IRQ_STAT: d = {28'h0000000, st.irq_stat};
            ADDR_IRQ_MASK: d = {28'h0000000, st.irq_mask};
            ADDR_CTRL: d = {31'h00000000, st.ctrl_en};
            default: d = '0;
        endcase
        return d;
    endfunction

    always_comb
    begin
        logic [RSV_W-1:0] v;
        logic [IRQ_W-1:0] ev;
        logic [IRQ_W-1:0] clr;
        logic clear;
        logic ign_now;
        logic take;
        v = '0;
        ev = '0;
        clr = '0;
        clear = 1'b0;
        ign_now = 1'b0;
        take = 1'b0;
        nxt_s = s_ff;
        nxt_s.rsv_valid = 1'b0;
        nxt_s.ob_valid = 1'b0;
        nxt_s.ready = 1'b1;
        nxt_s.resp = 1'b0;

        // Byte stream of the vector, low byte first
        case (s_ff.ost)
            OUT_B0:
            begin
                nxt_s.ob = s_ff.rsv[7:0];
                nxt_s.ob_valid = 1'b1;
                nxt_s.ost = OUT_B1;
            end
            OUT_B1:
            begin
                nxt_s.ob = s_ff.rsv[15:8];
                nxt_s.ob_valid = 1'b1;
                nxt_s.ost = OUT_B2;
            end
            OUT_B2:
            begin
                nxt_s.ob = s_ff.rsv[23:16];
                nxt_s.ob_valid = 1'b1;
                nxt_s.ost = OUT_IDLE;
            end
            default: nxt_s.ost = OUT_IDLE;
        endcase

        // Vector build at frame end
        if (fr_bus.done)
        begin
            if (s_ff.ctrl_en && !fr_bus.too_long)
            begin
                v[CNT_W-1:0] = fr_bus.byte_cnt;
                v[BIT_OK] = !fr_bus.crc_err && !fr_bus.sym_err;
                v[BIT_RANGE] = fr_bus.len_range;
                v[BIT_LEN_ERR] = fr_bus.len_err;
                v[BIT_CRC_ERR] = fr_bus.crc_err;
                v[BIT_CARRIER] = s_ff.carrier_seen;
                v[BIT_IGNORED] = s_ff.ignored_seen;
                nxt_s.rsv = v;
                nxt_s.rsv_valid = 1'b1;
                nxt_s.ost = OUT_B0;
                clear = 1'b1;
                ev[IRQ_VEC] = 1'b1;
                ev[IRQ_CRC] = fr_bus.crc_err;
            end
            else
                ign_now = 1'b1;
        end

        // Sticky history, a new event outlives the clear
        nxt_s.carrier_seen = (s_ff.carrier_seen & ~clear) | carrier_event;
        nxt_s.ignored_seen = (s_ff.ignored_seen & ~clear) | drop_event | ign_now;
        ev[IRQ_CARRIER] = carrier_event;
        ev[IRQ_IGNORED] = drop_event | ign_now;

        // Data phase of a write
        if (s_ff.wr_pend)
        begin
            case (s_ff.wr_addr)
                ADDR_IRQ_STAT: clr = hwdata[IRQ_W-1:0];
                ADDR_IRQ_MASK: nxt_s.irq_mask = hwdata[IRQ_W-1:0];
                ADDR_CTRL: nxt_s.ctrl_en = hwdata[CTRL_EN_BIT];
                default: clr = '0;
            endcase
        end
        nxt_s.irq_stat = (s_ff.irq_stat & ~clr) | ev;
        nxt_s.irq = |(nxt_s.irq_stat & nxt_s.irq_mask);

        // Address phase
        take = hsel && hready && htrans[1];
        nxt_s.wr_pend = take && hwrite;
        nxt_s.wr_addr = haddr[7:0];
        nxt_s.rdata = (take && !hwrite) ? read_reg(s_ff, haddr[7:0]) : '0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_ff <= '0;
            s_ff.ost <= OUT_IDLE;
            s_ff.ctrl_en <= CTRL_EN_RST;
            s_ff.irq_mask <= IRQ_MASK_RST;
            s_ff.ready <= 1'b1;
        end
        else
            s_ff <= nxt_s;
    end

    assign hrdata = s_ff.rdata;
    assign hreadyout = s_ff.ready;
    assign hresp = s_ff.resp;
    assign status_vector = s_ff.rsv;
    assign status_valid = s_ff.rsv_valid;
    assign vec_byte = s_ff.ob;
    assign vec_byte_valid = s_ff.ob_valid;
    assign irq = s_ff.irq;

    a_range_flag: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (fr_bus.done && s_ff.ctrl_en && !fr_bus.too_long) |=>
            status_valid && (status_vector[BIT_RANGE] == $past(fr_bus.len_range)))
        else $error("range flag not carried into vector");

    a_len_flag: assert property (
        @(posedge hclk) disable iff (!hresetn)
        status_valid |-> (status_vector[BIT_LEN_ERR] == $past(fr_bus.len_err))
            && !(status_vector[BIT_LEN_ERR] && status_vector[BIT_RANGE]))
        else $error("length check flag wrong");

    a_crc_flag: assert property (
        @(posedge hclk) disable iff (!hresetn)
        status_valid |-> status_vector[BIT_CRC_ERR] == $past(fr_bus.crc_err))
        else $error("crc flag wrong");

    a_carrier_seen: assert property (
        @(posedge hclk) disable iff (!hresetn)
        status_valid |-> status_vector[BIT_CARRIER] == $past(s_ff.carrier_seen))
        else $error("carrier event not reported");

    a_carrier_hold: assert property (
        @(posedge hclk) disable iff (!hresetn)
        carrier_event |=> s_ff.carrier_seen)
        else $error("carrier event lost");

    a_ignored_long: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (fr_bus.done && fr_bus.too_long) |=> s_ff.ignored_seen && !status_valid
            && s_ff.irq_stat[IRQ_IGNORED])
        else $error("long frame not marked ignored");

    a_byte_count: assert property (
        @(posedge hclk) disable iff (!hresetn)
        status_valid |-> status_vector[CNT_W-1:0] == $past(fr_bus.byte_cnt))
        else $error("byte count wrong");

    a_lsb_first: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (status_valid && !fr_bus.done) |=> vec_byte_valid
            && (vec_byte == $past(status_vector[7:0]))
            ##1 (!$past(fr_bus.done) && vec_byte == $past(status_vector[15:8], 2)) or $past(fr_bus.done))
        else $error("count not sent low byte first");

    a_ok_flag: assert property (
        @(posedge hclk) disable iff (!hresetn)
        status_valid |-> status_vector[BIT_OK]
            == (!status_vector[BIT_CRC_ERR] && !$past(fr_bus.sym_err)))
        else $error("received ok flag wrong");

    a_sticky_clear: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (status_valid && !$past(carrier_event) && !$past(drop_event))
            |-> !s_ff.carrier_seen && !s_ff.ignored_seen)
        else $error("sticky flags not cleared after report");

    // Register bus
    a_bus_okay: assert property (
        @(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp)
        else $error("bus not ready or not okay");

    a_status_read: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (hsel && hready && htrans[1] && !hwrite && haddr[7:0] == ADDR_STATUS)
            |=> hrdata == {8'h00, $past(status_vector)})
        else $error("status read data wrong");

    a_irqstat_read: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (hsel && hready && htrans[1] && !hwrite && haddr[7:0] == ADDR_IRQ_STAT)
            |=> hrdata == {28'h0000000, $past(s_ff.irq_stat)})
        else $error("interrupt status read wrong");

    a_read_idle: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h00000000)
        else $error("read data not zero outside a read");

    a_mask_write: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (s_ff.wr_pend && s_ff.wr_addr == ADDR_IRQ_MASK)
            |=> s_ff.irq_mask == $past(hwdata[IRQ_W-1:0]))
        else $error("mask write lost");

    a_ctrl_write: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (s_ff.wr_pend && s_ff.wr_addr == ADDR_CTRL)
            |=> s_ff.ctrl_en == $past(hwdata[CTRL_EN_BIT]))
        else $error("control write lost");

    // Interrupt status
    a_vec_set_wins: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (fr_bus.done && s_ff.ctrl_en && !fr_bus.too_long) |=> s_ff.irq_stat[IRQ_VEC])
        else $error("vector event lost");

    a_w1c_clear: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (s_ff.wr_pend && s_ff.wr_addr == ADDR_IRQ_STAT && hwdata[IRQ_VEC] && !fr_bus.done)
            |=> !s_ff.irq_stat[IRQ_VEC])
        else $error("status bit not cleared by write");

    a_irq_level: assert property (
        @(posedge hclk) disable iff (!hresetn)
        irq == |(s_ff.irq_stat & s_ff.irq_mask))
        else $error("interrupt level wrong");

    a_disabled_drop: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (fr_bus.done && !s_ff.ctrl_en)
            |=> !status_valid && s_ff.ignored_seen && s_ff.irq_stat[IRQ_IGNORED])
        else $error("frame taken while disabled");

    a_byte_stream: assert property (
        @(posedge hclk) disable iff (!hresetn)
        status_valid |=> vec_byte_valid [*3])
        else $error("vector byte stream broken");
endmodule

// ---- verification/medium_model.sv ----
`timescale 1ns/100ps
module medium_model (
    input wire logic hclk,
    output logic rx_frame,
    output logic rx_byte_en,
    output logic [7:0] rx_data,
    output logic rx_sym_err,
    output logic carrier_event,
    output logic drop_event
);
    import rsv_pkg::*;
    logic [7:0] bytes_q[$];
    initial
    begin
        rx_frame = 1'b0;
        rx_byte_en = 1'b0;
        rx_data = 8'h00;
        rx_sym_err = 1'b0;
        carrier_event = 1'b0;
        drop_event = 1'b0;
    end
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
        for (int k = 0; k < 8; k++)
            c = (c[0] ^ d[k]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        return c;
    endfunction
    // One-cycle carrier or drop pulse between frames
    task automatic pulse(input logic drop);
        @(posedge hclk);
        carrier_event <= !drop;
        drop_event <= drop;
        @(posedge hclk);
        carrier_event <= 1'b0;
        drop_event <= 1'b0;
    endtask
    // Whole frame, one byte every other cycle, line inverted between bytes
    task automatic send(input logic [15:0] tl, input int dlen, input logic bad, input logic sym);
        logic [31:0] c;
        bytes_q = {};
        c = CRC_INIT;
        for (int k = 0; k < 12; k++)
            bytes_q.push_back(8'(k + 1));
        bytes_q.push_back(tl[15:8]);
        bytes_q.push_back(tl[7:0]);
        for (int k = 0; k < dlen; k++)
            bytes_q.push_back(8'(k * 7 + 3));
        foreach (bytes_q[k])
            c = crc_step(c, bytes_q[k]);
        c = ~c ^ {31'h0, bad};
        for (int k = 0; k < 4; k++)
            bytes_q.push_back(c[k*8 +: 8]);
        @(posedge hclk);
        rx_frame <= 1'b1;
        foreach (bytes_q[k])
        begin
            @(posedge hclk);
            rx_byte_en <= 1'b1;
            rx_data <= bytes_q[k];
            rx_sym_err <= sym && (k == 20);
            @(posedge hclk);
            rx_byte_en <= 1'b0;
            rx_data <= ~bytes_q[k];
            rx_sym_err <= 1'b0;
        end
        @(posedge hclk);
        rx_frame <= 1'b0;
    endtask
endmodule

// ---- verification/rx_status_vector_gen_tb.sv ----
`timescale 1ns/100ps
module rx_status_vector_gen_tb;
    import rsv_pkg::*;
    typedef struct {logic [15:0] tl; int dlen; logic bad; logic sym; int pre;} case_type;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic rx_frame;
    logic rx_byte_en;
    logic [7:0] rx_data;
    logic rx_sym_err;
    logic carrier_event;
    logic drop_event;
    logic [RSV_W-1:0] status_vector;
    logic status_valid;
    logic [7:0] vec_byte;
    logic vec_byte_valid;
    logic irq;
    logic [31:0] rd;
    logic got;
    int miscompares = 0;
    int n_compared = 0;
    case_type cases[5] = '{'{16'h0800, 46, 1'b0, 1'b0, 0}, '{16'h05dc, 50, 1'b0, 1'b0, 1},
        '{16'h05dd, 50, 1'b1, 1'b0, 2}, '{16'h0020, 46, 1'b0, 1'b1, 0},
        '{16'h0030, 48, 1'b0, 1'b0, 0}};
    always #5 hclk = ~hclk;
    rx_status_vector_gen rx_status_vector_gen_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .rx_frame(rx_frame), .rx_byte_en(rx_byte_en), .rx_data(rx_data),
        .rx_sym_err(rx_sym_err), .carrier_event(carrier_event), .drop_event(drop_event),
        .status_vector(status_vector), .status_valid(status_valid), .vec_byte(vec_byte),
        .vec_byte_valid(vec_byte_valid), .irq(irq));
    medium_model medium_model_i (.hclk(hclk), .rx_frame(rx_frame), .rx_byte_en(rx_byte_en),
        .rx_data(rx_data), .rx_sym_err(rx_sym_err), .carrier_event(carrier_event),
        .drop_event(drop_event));
    task automatic close_out();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_ready();
        for (int k = 0; k < 50; k++)
        begin
            @(posedge hclk);
            if (hreadyout === 1'b1)
                return;
        end
        miscompares++;
        close_out();
    endtask
    task automatic wait_valid(output logic seen);
        seen = 1'b0;
        for (int k = 0; k < 40 && !seen; k++)
        begin
            @(posedge hclk);
            seen = (status_valid === 1'b1);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        r = hrdata;
    endtask
    function automatic logic [23:0] exp_vec(input case_type c, input logic car, input logic ign);
        logic [23:0] v;
        v = 24'h0;
        v[15:0] = 16'(c.dlen + 18);
        v[BIT_OK] = !c.bad && !c.sym;
        v[BIT_RANGE] = c.tl > MAX_LEN_FIELD;
        v[BIT_LEN_ERR] = c.tl <= MAX_LEN_FIELD
            && c.dlen != int'((c.tl < MIN_DATA) ? MIN_DATA : c.tl);
        v[BIT_CRC_ERR] = c.bad;
        v[BIT_CARRIER] = car;
        v[BIT_IGNORED] = ign;
        return v;
    endfunction
    task automatic run_case(input case_type c, input logic car, input logic ign);
        logic [23:0] v;
        v = exp_vec(c, car, ign);
        medium_model_i.send(c.tl, c.dlen, c.bad, c.sym);
        wait_valid(got);
        check("status_valid", {31'h0, got}, 32'h1);
        check("vector", {8'h0, status_vector}, {8'h0, v});
        for (int k = 0; k < 3; k++)
        begin
            @(posedge hclk);
            check("vec_byte", {23'h0, vec_byte_valid, vec_byte}, {24'h1, v[k*8 +: 8]});
        end
        bus(1'b0, ADDR_STATUS, 32'h0, rd);
        check("status_reg", rd, {8'h0, v});
    endtask
    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        check("hreadyout", {31'h0, hreadyout}, 32'h1);
        check("hresp", {31'h0, hresp}, 32'h0);
        bus(1'b0, ADDR_CTRL, 32'h0, rd);
        check("ctrl", rd, 32'h1);
        bus(1'b0, ADDR_IRQ_MASK, 32'h0, rd);
        check("irq_mask", rd, 32'h0);
        bus(1'b0, 8'h10, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        $display("test registers done");
        bus(1'b1, ADDR_IRQ_MASK, 32'h1, rd);
        run_case(cases[0], 1'b0, 1'b0);
        check("irq_set", {31'h0, irq}, 32'h1);
        bus(1'b0, ADDR_IRQ_STAT, 32'h0, rd);
        check("irq_stat", rd, 32'h1);
        bus(1'b1, ADDR_IRQ_STAT, 32'hf, rd);
        repeat (3) @(posedge hclk);
        check("irq_clear", {31'h0, irq}, 32'h0);
        bus(1'b0, ADDR_IRQ_STAT, 32'h0, rd);
        check("irq_stat_clear", rd, 32'h0);
        $display("test interrupt done");
        for (int i = 1; i < 5; i++)
        begin
            if (cases[i].pre != 0)
                medium_model_i.pulse(cases[i].pre == 2);
            run_case(cases[i], cases[i].pre == 1, cases[i].pre == 2);
        end
        $display("test flags done");
        medium_model_i.send(16'h0800, 6233, 1'b0, 1'b0);
        wait_valid(got);
        check("long_no_vector", {31'h0, got}, 32'h0);
        bus(1'b1, ADDR_IRQ_STAT, 32'hf, rd);
        bus(1'b1, ADDR_CTRL, 32'h0, rd);
        bus(1'b0, ADDR_CTRL, 32'h0, rd);
        check("ctrl_off", rd, 32'h0);
        medium_model_i.send(16'h0800, 46, 1'b0, 1'b0);
        wait_valid(got);
        check("off_no_vector", {31'h0, got}, 32'h0);
        bus(1'b0, ADDR_IRQ_STAT, 32'h0, rd);
        check("irq_stat_ignored", rd, 32'h8);
        bus(1'b1, ADDR_CTRL, 32'h1, rd);
        run_case(cases[0], 1'b0, 1'b1);
        $display("test long frame done");
        close_out();
    end
endmodule
